/* common/alarm_mute_consts.svh */
/*
  Register offsets, field positions, reset values and widths for the
  alarm mask and DAC mute block.
  Assumes it is included by bare name, once per compilation unit.
*/
`ifndef ALARM_MUTE_CONSTS_SVH
`define ALARM_MUTE_CONSTS_SVH

// ----------------------------------------------------------------------
// register access port
// ----------------------------------------------------------------------
`define AM_ADDR_W 12
`define AM_DATA_W 8

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define AM_OFS_SYS_ALARM 12'h430
`define AM_OFS_ALARM_MASK 12'h431
`define AM_OFS_MUTE_MASK 12'h432
`define AM_OFS_DAC_MUTE_RECOVERY 12'h433

// ----------------------------------------------------------------------
// field positions, shared by alarm, alarm mask, mute mask and recovery
// ----------------------------------------------------------------------
`define AM_BIT_LINK_LOSS 7
`define AM_BIT_LOSS_TIMEOUT 6
`define AM_BIT_CHECKSUM 5
`define AM_BIT_SYS_RESET 1
`define AM_BIT_SYNC_REF 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define AM_RST_ALARM_MASK 8'h00
`define AM_RST_MUTE_MASK 8'h21
`define AM_RST_DAC_MUTE_RECOVERY 8'hA0
`define AM_RST_DATA 8'h00

// ----------------------------------------------------------------------
// link-loss timer and lane count
// ----------------------------------------------------------------------
`define AM_TIMER_W 16
`define AM_TIMER_ZERO 16'h0000
`define AM_TIMER_ONE 16'h0001
`define AM_LANES 2

`endif

/* common/alarm_mute_pkg.sv */
/*
  Types for the alarm mask and DAC mute block: fault carrier and the
  state records of both modules.
  Assumes alarm_mute_consts.svh is on the include path.
*/
`include "alarm_mute_consts.svh"

package alarm_mute_pkg;

  // raw fault indications from the link and clocking logic
  typedef struct packed {
    logic link_up;
    logic serial_link_enable;
    logic mode_64b66b;
    logic [`AM_LANES-1:0] lane_enable;
    logic [`AM_LANES-1:0] checksum_fault;
    logic sync_ref_misalign_div;
    logic sync_ref_misalign_link;
  } fault_in_t;

  // sticky alarm set, one bit per source
  typedef struct packed {
    logic link_loss_alarm;
    logic loss_timeout_alarm;
    logic checksum_alarm;
    logic sys_reset_alarm;
    logic sync_ref_alarm;
  } alarm_set_t;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_COUNT = 2'b01,
    TMR_EXPIRED = 2'b10
  } timer_state_t;

  typedef struct packed {
    timer_state_t st;
    logic [`AM_TIMER_W-1:0] cnt;
    logic expired;
  } timer_reg_t;

  typedef struct packed {
    alarm_set_t alarm;
    logic [`AM_DATA_W-1:0] alarm_mask;
    logic [`AM_DATA_W-1:0] mute_mask;
    logic [`AM_DATA_W-1:0] dac_mute_recovery;
    logic link_up_prev;
    logic alarm_out;
    logic dac_mute;
    logic [`AM_DATA_W-1:0] rdata;
  } ctrl_reg_t;

endpackage

/* core/link_loss_timer.sv */
/*
  Link-loss timer: counts cycles while the serial link is enabled and
  down, and pulses once when the programmed limit is exceeded.
  Assumes the limit is stable while the link is down.
*/
`timescale 1ns/1ps
`include "alarm_mute_consts.svh"

module link_loss_timer
  import alarm_mute_pkg::*;
(
  input wire logic clock_i, // 100 MHz device clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic link_down_i, // link down while enabled
  input wire logic [`AM_TIMER_W-1:0] limit_i, // allowed down cycles
  output logic expired_o // one-cycle pulse on expiry
);

  timer_reg_t r_r;
  timer_reg_t r_nxt;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    r_nxt.expired = 1'b0;
    case (r_r.st)
      TMR_IDLE: begin
        r_nxt.cnt = `AM_TIMER_ZERO;
        if (link_down_i) begin
          r_nxt.st = TMR_COUNT;
          r_nxt.cnt = `AM_TIMER_ONE;
        end
      end
      TMR_COUNT: begin
        if (!link_down_i) begin
          r_nxt.st = TMR_IDLE;
        end else if (r_r.cnt > limit_i) begin
          // strictly longer than allowed
          r_nxt.st = TMR_EXPIRED;
          r_nxt.expired = 1'b1;
        end else if (r_r.cnt != {`AM_TIMER_W{1'b1}}) begin
          r_nxt.cnt = r_r.cnt + `AM_TIMER_ONE;
        end
      end
      TMR_EXPIRED: begin
        // one alarm per outage; rearm only when the link returns
        if (!link_down_i) begin
          r_nxt.st = TMR_IDLE;
        end
      end
      default: begin
        r_nxt.st = TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_r <= '{st: TMR_IDLE, cnt: `AM_TIMER_ZERO, expired: 1'b0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign expired_o = r_r.expired;

endmodule

/* core/alarm_mute_ctrl.sv */
/*
  Alarm mask and DAC mute control: sticky system alarms, their masks
  onto the alarm output, and the DAC mute with its recovery modes.
  Assumes register writes and reads arrive as one-cycle strobes on the
  device clock, and fault inputs are synchronous to that clock.
*/
// Function
// - link-loss alarm mask bit 7 keeps that alarm off the alarm output.
// - loss-timeout mask bit 6, reset 0, keeps timer alarm off output.
// - checksum mask bit 5, reset 0, keeps checksum alarm off output.
// - sync-ref mask bit 0, reset 0, keeps sync-ref alarm off output.
// - checksum mute mask bit 5 clear lets checksum alarm mute DACs.
// - sync-ref mute mask bit 0 clear lets sync-ref alarm mute DACs.
// - link-loss recovery 0 mutes until alarm cleared; 1 until link up.
// - checksum recovery 0 mutes until alarm cleared; 1 until fault ends.
// - link-up falling while enabled sets link-loss alarm; write 1 clears.
// - link down longer than timer limit sets loss-timeout alarm.
// - checksum fault on enabled lane in 64b/66b sets checksum alarm.
// - misaligned sync-ref edge from dividers, or from link while enabled, sets its alarm.
`timescale 1ns/1ps
`include "alarm_mute_consts.svh"

module alarm_mute_ctrl
  import alarm_mute_pkg::*;
(
  input wire logic clock_i, // 100 MHz device clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [`AM_ADDR_W-1:0] reg_addr_i, // register offset
  input wire logic [`AM_DATA_W-1:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe, one cycle
  input wire logic reg_rd_i, // read strobe, one cycle
  input wire fault_in_t fault_i, // raw fault indications
  input wire logic [`AM_TIMER_W-1:0] link_loss_timer_i, // down limit
  output logic [`AM_DATA_W-1:0] reg_rdata_o, // read data, next cycle
  output logic alarm_o, // masked alarm output, high active
  output logic dac_mute_o // DAC mute, high active
);

  ctrl_reg_t r_r;
  ctrl_reg_t r_nxt;
  alarm_set_t set_ev;
  alarm_set_t clr_ev;
  logic timeout_pulse;
  logic link_down;
  logic checksum_fault_now;
  logic wr_alarm;
  logic link_loss_mute;
  logic checksum_mute;
  logic sync_ref_mute;
  logic [`AM_DATA_W-1:0] alarm_view;

  // ----------------------------------------------------------------------
  // fault detection
  // ----------------------------------------------------------------------
  assign link_down = fault_i.serial_link_enable & ~fault_i.link_up;

  // faults on lanes that are switched off are ignored
  assign checksum_fault_now = fault_i.mode_64b66b &
    (|(fault_i.checksum_fault & fault_i.lane_enable));

  link_loss_timer u_timer (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .link_down_i(link_down),
    .limit_i(link_loss_timer_i),
    .expired_o(timeout_pulse)
  );

  always_comb begin
    set_ev = '0;
    set_ev.link_loss_alarm = fault_i.serial_link_enable &
      r_r.link_up_prev & ~fault_i.link_up;
    set_ev.loss_timeout_alarm = timeout_pulse;
    set_ev.checksum_alarm = checksum_fault_now;
    // the link side only counts while the link is enabled
    set_ev.sync_ref_alarm = fault_i.sync_ref_misalign_div |
      (fault_i.sync_ref_misalign_link &
       fault_i.serial_link_enable);
  end

  // ----------------------------------------------------------------------
  // write-one-to-clear decode
  // ----------------------------------------------------------------------
  assign wr_alarm = reg_wr_i && (reg_addr_i == `AM_OFS_SYS_ALARM);

  always_comb begin
    clr_ev = '0;
    if (wr_alarm) begin
      clr_ev.link_loss_alarm = reg_wdata_i[`AM_BIT_LINK_LOSS];
      clr_ev.loss_timeout_alarm = reg_wdata_i[`AM_BIT_LOSS_TIMEOUT];
      clr_ev.checksum_alarm = reg_wdata_i[`AM_BIT_CHECKSUM];
      clr_ev.sys_reset_alarm = reg_wdata_i[`AM_BIT_SYS_RESET];
      clr_ev.sync_ref_alarm = reg_wdata_i[`AM_BIT_SYNC_REF];
    end
  end

  // ----------------------------------------------------------------------
  // alarm register view
  // ----------------------------------------------------------------------
  always_comb begin
    alarm_view = `AM_RST_DATA;
    alarm_view[`AM_BIT_LINK_LOSS] = r_r.alarm.link_loss_alarm;
    alarm_view[`AM_BIT_LOSS_TIMEOUT] = r_r.alarm.loss_timeout_alarm;
    alarm_view[`AM_BIT_CHECKSUM] = r_r.alarm.checksum_alarm;
    alarm_view[`AM_BIT_SYS_RESET] = r_r.alarm.sys_reset_alarm;
    alarm_view[`AM_BIT_SYNC_REF] = r_r.alarm.sync_ref_alarm;
  end

  // ----------------------------------------------------------------------
  // mute sources
  // ----------------------------------------------------------------------
  // no mute mask exists for link loss, so it always takes part
  always_comb begin
    if (r_r.dac_mute_recovery[`AM_BIT_LINK_LOSS]) begin
      // auto recovery: muted only while the link is still down
      link_loss_mute = r_r.alarm.link_loss_alarm & link_down;
    end else begin
      link_loss_mute = r_r.alarm.link_loss_alarm;
    end
  end

  always_comb begin
    checksum_mute = 1'b0;
    if (!r_r.mute_mask[`AM_BIT_CHECKSUM]) begin
      if (r_r.dac_mute_recovery[`AM_BIT_CHECKSUM]) begin
        checksum_mute = r_r.alarm.checksum_alarm &
          checksum_fault_now;
      end else begin
        checksum_mute = r_r.alarm.checksum_alarm;
      end
    end
  end

  assign sync_ref_mute = r_r.alarm.sync_ref_alarm &
    ~r_r.mute_mask[`AM_BIT_SYNC_REF];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    r_nxt.link_up_prev = fault_i.link_up;

    // a new event in the clearing cycle keeps its bit set
    r_nxt.alarm = (r_r.alarm & ~clr_ev) | set_ev;

    if (reg_wr_i) begin
      case (reg_addr_i)
        `AM_OFS_ALARM_MASK: begin
          r_nxt.alarm_mask = reg_wdata_i;
        end
        `AM_OFS_MUTE_MASK: begin
          r_nxt.mute_mask = reg_wdata_i;
        end
        `AM_OFS_DAC_MUTE_RECOVERY: begin
          r_nxt.dac_mute_recovery = reg_wdata_i;
        end
        default: begin
        end
      endcase
    end

    // reads return the state before any write in the same cycle
    r_nxt.rdata = r_r.rdata;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `AM_OFS_SYS_ALARM: begin
          r_nxt.rdata = alarm_view;
        end
        `AM_OFS_ALARM_MASK: begin
          r_nxt.rdata = r_r.alarm_mask;
        end
        `AM_OFS_MUTE_MASK: begin
          r_nxt.rdata = r_r.mute_mask;
        end
        `AM_OFS_DAC_MUTE_RECOVERY: begin
          r_nxt.rdata = r_r.dac_mute_recovery;
        end
        default: begin
          r_nxt.rdata = `AM_RST_DATA;
        end
      endcase
    end

    // registered from current alarms, so the outputs lag by one edge
    r_nxt.alarm_out =
      (r_r.alarm.link_loss_alarm &
       ~r_r.alarm_mask[`AM_BIT_LINK_LOSS]) |
      (r_r.alarm.loss_timeout_alarm &
       ~r_r.alarm_mask[`AM_BIT_LOSS_TIMEOUT]) |
      (r_r.alarm.checksum_alarm &
       ~r_r.alarm_mask[`AM_BIT_CHECKSUM]) |
      (r_r.alarm.sync_ref_alarm &
       ~r_r.alarm_mask[`AM_BIT_SYNC_REF]);

    r_nxt.dac_mute = link_loss_mute | checksum_mute | sync_ref_mute;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // the reset alarm comes up set so software can see a reset happened
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_r.alarm <= '{link_loss_alarm: 1'b0, loss_timeout_alarm: 1'b0,
                     checksum_alarm: 1'b0, sys_reset_alarm: 1'b1,
                     sync_ref_alarm: 1'b0};
      r_r.alarm_mask <= `AM_RST_ALARM_MASK;
      r_r.mute_mask <= `AM_RST_MUTE_MASK;
      r_r.dac_mute_recovery <= `AM_RST_DAC_MUTE_RECOVERY;
      r_r.link_up_prev <= 1'b0;
      r_r.alarm_out <= 1'b0;
      r_r.dac_mute <= 1'b0;
      r_r.rdata <= `AM_RST_DATA;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign reg_rdata_o = r_r.rdata;
  assign alarm_o = r_r.alarm_out;
  assign dac_mute_o = r_r.dac_mute;

endmodule

/* testbench/alarm_mute_ctrl_chk.sv */
/*
  Port-level checker for alarm_mute_ctrl, bound into alarm_mute_ctrl.
  Assumes the package and the constants header are compiled first.
*/
`timescale 1ns/1ps
`include "alarm_mute_consts.svh"

module alarm_mute_ctrl_chk
  import alarm_mute_pkg::*;
(
  input wire logic clock_i, // device clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [`AM_ADDR_W-1:0] reg_addr_i, // register offset
  input wire logic [`AM_DATA_W-1:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire fault_in_t fault_i, // fault indications
  input wire logic [`AM_TIMER_W-1:0] link_loss_timer_i, // down limit
  input wire logic [`AM_DATA_W-1:0] reg_rdata_o, // read data
  input wire logic alarm_o, // masked alarm
  input wire logic dac_mute_o // dac mute
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // shadow registers
  // ----------------------------------------------------------------
  // masks are copied from writes so relations can name their effect
  logic [`AM_DATA_W-1:0] am_r;
  logic [`AM_DATA_W-1:0] mm_r;
  logic [`AM_DATA_W-1:0] rc_r;
  logic [`AM_TIMER_W:0] dn_cnt_r;
  logic dn;
  logic ck_ev;
  logic sr_ev;
  assign dn = !fault_i.link_up && fault_i.serial_link_enable;
  assign ck_ev = fault_i.mode_64b66b &&
    (|(fault_i.lane_enable & fault_i.checksum_fault));
  assign sr_ev = fault_i.sync_ref_misalign_div ||
    (fault_i.sync_ref_misalign_link && fault_i.serial_link_enable);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      am_r <= `AM_RST_ALARM_MASK;
      mm_r <= `AM_RST_MUTE_MASK;
      rc_r <= `AM_RST_DAC_MUTE_RECOVERY;
      dn_cnt_r <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == `AM_OFS_ALARM_MASK) am_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `AM_OFS_MUTE_MASK) mm_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `AM_OFS_DAC_MUTE_RECOVERY) rc_r <= reg_wdata_i;
      if (!dn) dn_cnt_r <= '0;
      else if (!dn_cnt_r[`AM_TIMER_W]) dn_cnt_r <= dn_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  link_mute_a:
    assert property ($past(rst_n_i) && $fell(fault_i.link_up) &&
      fault_i.serial_link_enable ##1 dn |=> dac_mute_o)
    else $error("link loss did not mute");
  link_alarm_a:
    assert property ($past(rst_n_i) && $fell(fault_i.link_up) &&
      fault_i.serial_link_enable && !am_r[7] |-> ##2 alarm_o)
    else $error("link loss did not raise alarm");
  mask_all_a:
    assert property ($past(am_r[7] && am_r[6] && am_r[5] && am_r[0])
      |-> !alarm_o)
    else $error("alarm seen with all sources masked");
  csum_mute_a:
    assert property (ck_ev && !mm_r[5] ##1 ck_ev |=> dac_mute_o)
    else $error("checksum fault did not mute");
  sref_mute_a:
    assert property (sr_ev && !mm_r[0] |-> ##2 dac_mute_o)
    else $error("sync ref fault did not mute");
  latch_hold_a:
    assert property (dac_mute_o && !rc_r[7] && !rc_r[5] &&
      !$past(reg_wr_i) |=> dac_mute_o)
    else $error("latched mute ended without a write");
  timeout_a:
    assert property (!am_r[6] &&
      dn_cnt_r == ({1'b0, link_loss_timer_i} + 17'h00006) |-> alarm_o)
    else $error("link timeout gave no alarm");
  mask_read_a:
    assert property (reg_rd_i && reg_addr_i == `AM_OFS_ALARM_MASK
      |=> reg_rdata_o == $past(am_r))
    else $error("alarm mask read back wrong");

  cover property (dac_mute_o && !alarm_o);
  cover property ($fell(dac_mute_o));
  cover property (dn_cnt_r > {1'b0, link_loss_timer_i});
endmodule

bind alarm_mute_ctrl alarm_mute_ctrl_chk u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .fault_i(fault_i), .link_loss_timer_i(link_loss_timer_i),
  .reg_rdata_o(reg_rdata_o), .alarm_o(alarm_o), .dac_mute_o(dac_mute_o)
);

/* testbench/alarm_mute_ctrl_test.sv */
/*
  Self-checking bench for alarm_mute_ctrl: registers, link loss,
  timeout, checksum and sync-ref alarms with masks and recovery.
  Assumes inputs change on the falling clock edge.
*/
`timescale 1ns/1ps
`include "alarm_mute_consts.svh"
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h exp %h", $time, got, exp); \
  end \
end

module alarm_mute_ctrl_test
  import alarm_mute_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [`AM_ADDR_W-1:0] addr = '0;
  logic [`AM_DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  fault_in_t f = '0;
  logic [`AM_TIMER_W-1:0] lim = 16'h000A;
  logic [`AM_DATA_W-1:0] rdata;
  logic alarm;
  logic mute;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 clock_i = ~clock_i;

  alarm_mute_ctrl u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .fault_i(f),
    .link_loss_timer_i(lim), .reg_rdata_o(rdata), .alarm_o(alarm),
    .dac_mute_o(mute)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // two cycles per write so the strobe never rises twice in one step
  task automatic wrr(input logic [11:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    `CHK(rdata, e);
    cyc(1);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rdc(12'h430, 8'h02);
    rdc(12'h431, 8'h00);
    rdc(12'h432, 8'h21);
    rdc(12'h433, 8'hA0);
    rdc(12'h434, 8'h00);
    wrr(12'h430, 8'hFF);
    rdc(12'h430, 8'h00);
  endtask

  task automatic t_link();
    f.serial_link_enable = 1'b1;
    f.link_up = 1'b1;
    cyc(3);
    f.link_up = 1'b0;
    cyc(2);
    `CHK(alarm, 1'b1);
    `CHK(mute, 1'b1);
    cyc(18);
    rdc(12'h430, 8'hC0);
    f.link_up = 1'b1;
    cyc(2);
    `CHK(mute, 1'b0);
    wrr(12'h431, 8'h80);
    `CHK(alarm, 1'b1);
    wrr(12'h431, 8'hC0);
    `CHK(alarm, 1'b0);
    wrr(12'h430, 8'hC0);
    wrr(12'h433, 8'h00);
    f.link_up = 1'b0;
    cyc(2);
    `CHK(alarm, 1'b0);
    `CHK(mute, 1'b1);
    f.link_up = 1'b1;
    cyc(4);
    `CHK(mute, 1'b1);
    wrr(12'h430, 8'h80);
    `CHK(mute, 1'b0);
    wrr(12'h431, 8'h00);
  endtask

  task automatic t_csum();
    // outside the 64b/66b modes a lane fault must not raise the alarm
    f.lane_enable = 2'b01;
    f.checksum_fault = 2'b01;
    cyc(2);
    `CHK(alarm, 1'b0);
    f.mode_64b66b = 1'b1;
    f.lane_enable = 2'b01;
    f.checksum_fault = 2'b10;
    cyc(2);
    `CHK(alarm, 1'b0);
    f.checksum_fault = 2'b01;
    cyc(1);
    f.checksum_fault = 2'b00;
    cyc(2);
    `CHK(alarm, 1'b1);
    `CHK(mute, 1'b0);
    wrr(12'h431, 8'h20);
    `CHK(alarm, 1'b0);
    wrr(12'h430, 8'h20);
    wrr(12'h432, 8'h01);
    wrr(12'h433, 8'h20);
    f.checksum_fault = 2'b01;
    cyc(2);
    `CHK(mute, 1'b1);
    f.checksum_fault = 2'b00;
    cyc(2);
    `CHK(mute, 1'b0);
    wrr(12'h430, 8'h20);
    wrr(12'h433, 8'h00);
    f.checksum_fault = 2'b01;
    cyc(1);
    f.checksum_fault = 2'b00;
    cyc(4);
    `CHK(mute, 1'b1);
    wrr(12'h430, 8'h20);
    `CHK(mute, 1'b0);
    wrr(12'h431, 8'h00);
    wrr(12'h432, 8'h21);
    wrr(12'h433, 8'hA0);
  endtask

  task automatic t_sref();
    f.sync_ref_misalign_div = 1'b1;
    cyc(1);
    f.sync_ref_misalign_div = 1'b0;
    cyc(2);
    `CHK(alarm, 1'b1);
    `CHK(mute, 1'b0);
    wrr(12'h431, 8'hE1);
    `CHK(alarm, 1'b0);
    rdc(12'h431, 8'hE1);
    wrr(12'h432, 8'h20);
    `CHK(mute, 1'b1);
    wrr(12'h430, 8'h01);
    `CHK(mute, 1'b0);
    f.sync_ref_misalign_link = 1'b1;
    cyc(1);
    f.sync_ref_misalign_link = 1'b0;
    cyc(2);
    `CHK(mute, 1'b1);
    rdc(12'h430, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    cyc(20);
    rst_n_i = 1'b1;
    cyc(1);
    t_regs();
    t_link();
    t_csum();
    t_sref();
    tally_and_finish();
  end
endmodule
